//--- logic/pswrc_pkg.sv
package pswrc_pkg;
	// ****************************************
	// Timing at the 250 MHz system clock
	// ****************************************
	localparam int unsigned CLK_KHZ      = 250000;
	localparam int unsigned PULSE_MS     = 50;
	localparam int unsigned PULSE_CYC    = PULSE_MS * CLK_KHZ;
	localparam int unsigned RESUME_US    = 1000;
	localparam int unsigned RESUME_CYC   = RESUME_US * CLK_KHZ / 1000;
	localparam int unsigned RESUME_MAX   = 2 * CLK_KHZ;
	localparam int unsigned PHY_RST_US   = 100;
	localparam int unsigned PHY_RST_CYC  = PHY_RST_US * CLK_KHZ / 1000;
	localparam int unsigned SOFT_RST_US  = 2;
	localparam int unsigned SOFT_RST_CYC = SOFT_RST_US * CLK_KHZ / 1000;
	localparam int unsigned TMR_W        = 24;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFS_PWR  = 8'h00;
	localparam logic [7:0] OFS_INT  = 8'h04;
	localparam logic [7:0] OFS_IEN  = 8'h08;
	localparam logic [7:0] OFS_WAKE = 8'h0C;
	localparam logic [7:0] OFS_PHY  = 8'h10;
	localparam logic [7:0] OFS_RST  = 8'h14;
	localparam logic [7:0] OFS_NONE = 8'hFF;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int PWR_READY   = 0;
	localparam int PWR_OUT_EN  = 1;
	localparam int PWR_FRM_EN  = 2;
	localparam int PWR_CAR_EN  = 3;
	localparam int PWR_PULSE   = 4;
	localparam int PWR_WST     = 5;
	localparam int PWR_PHY_RST = 10;
	localparam int PWR_SEL     = 12;
	localparam int INT_WAKE    = 0;
	localparam int PHY_GPD     = 0;
	localparam int PHY_EDPD    = 1;
	localparam int PHY_ON      = 8;
	localparam int PHY_EFLAG   = 9;
	localparam int RST_SOFT    = 0;
	localparam int RST_EBUSY   = 1;

	// ****************************************
	// Codes and states
	// ****************************************
	localparam logic [1:0] SEL_FULL    = 2'h0;
	localparam logic [1:0] SEL_LISTEN  = 2'h1;
	localparam logic [1:0] SEL_DEEP    = 2'h2;
	localparam logic [1:0] WST_NONE    = 2'h0;
	localparam logic [1:0] WST_CARRIER = 2'h1;
	localparam logic [1:0] WST_FRAME   = 2'h2;
	localparam logic [2:0] HSIZE_WORD  = 3'h2;

	typedef enum logic [1:0] {
		ST_FULL,
		ST_LISTEN,
		ST_DEEP,
		ST_RESUME
	} pswrc_state_t;
endpackage : pswrc_pkg

//--- logic/pswrc_timer.sv
`timescale 1ns/1ps
module pswrc_timer #(
	parameter int unsigned W   = 24,
	parameter int unsigned CNT = 1
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// Control
	input  wire logic i_start,
	input  wire logic i_stop,
	// Status
	output logic      o_busy,
	output logic      o_done
);
	// ****************************************
	// Parameter check
	// ****************************************
	if (CNT == 0 || W > 31 || CNT > (32'h1 << W) - 1) begin : g_bad
		$error("pswrc_timer: CNT does not fit W");
	end

	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic         next_done;

	// Next count: stop wins over start
	always_comb begin
		next_cnt  = cnt;
		next_done = 1'b0;
		if (i_stop) begin
			next_cnt = '0;
		end else if (i_start) begin
			next_cnt = CNT[W-1:0];
		end else if (cnt != '0) begin
			next_cnt  = cnt - 1'b1;
			next_done = (cnt == {{(W-1){1'b0}}, 1'b1});
		end
	end

	// Count register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt    <= '0;
			o_done <= 1'b0;
		end else begin
			cnt    <= next_cnt;
			o_done <= next_done;
		end
	end

	assign o_busy = (cnt != '0);

	// ****************************************
	// Checks
	// ****************************************
	a_timer_load: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_start && !i_stop |=> cnt == CNT[W-1:0])
		else $error("timer not loaded");
endmodule : pswrc_timer

//--- logic/pswrc_rst_dist.sv
`timescale 1ns/1ps
module pswrc_rst_dist (
	// Clock and power-on reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// Reset sources
	input  wire logic i_ext,
	input  wire logic i_soft,
	input  wire logic i_phy,
	// Reset outputs
	output logic      o_rst_pll,
	output logic      o_rst_host,
	output logic      o_rst_keep,
	output logic      o_rst_mii,
	output logic      o_rst_mac,
	output logic      o_rst_phy,
	output logic      o_reload,
	output logic      o_strap
);
	logic       por;
	logic       full_q;
	logic       soft_q;
	logic       full;
	logic [7:0] rv;
	logic [7:0] next_rv;

	// Power-on and pin reset act alike
	assign full = por | i_ext;

	// Which circuitry each source clears
	always_comb begin
		next_rv[0] = full;
		next_rv[1] = full | i_soft;
		next_rv[2] = full;
		next_rv[3] = full | i_soft;
		next_rv[4] = full | i_soft;
		next_rv[5] = full | i_phy;
		next_rv[6] = (full_q & ~full) | (soft_q & ~i_soft);
		next_rv[7] = full_q & ~full;
	end

	// Output and edge registers
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			por    <= 1'b1;
			full_q <= 1'b1;
			soft_q <= 1'b0;
			rv     <= 8'h3F;
		end else begin
			por    <= 1'b0;
			full_q <= full;
			soft_q <= i_soft;
			rv     <= next_rv;
		end
	end

	assign {o_strap, o_reload, o_rst_phy, o_rst_mac} = rv[7:4];
	assign {o_rst_mii, o_rst_keep, o_rst_host, o_rst_pll} = rv[3:0];

	// ****************************************
	// Checks
	// ****************************************
	a_soft_scope: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_soft && !full && !i_phy |=>
			o_rst_host && o_rst_mac && !o_rst_keep && !o_rst_phy)
		else $error("soft reset scope wrong");

	a_reload_after: assert property (
		@(posedge i_clk) disable iff (i_rst)
		$fell(full) |=> o_reload && o_strap)
		else $error("no reload after reset");
endmodule : pswrc_rst_dist

//--- logic/pswrc_top.sv
`timescale 1ns/1ps
module pswrc_top #(
	parameter int unsigned P_PULSE_CYC  = pswrc_pkg::PULSE_CYC,
	parameter int unsigned P_RESUME_CYC = pswrc_pkg::RESUME_CYC,
	parameter int unsigned P_PHY_CYC    = pswrc_pkg::PHY_RST_CYC
) (
	// Clock and reset
	input  wire logic        I_SYS_CLK,
	input  wire logic        I_SYS_RST,
	input  wire logic        I_EXT_RESET_N,
	// AHB-Lite slave
	input  wire logic        I_HSEL,
	input  wire logic [31:0] I_HADDR,
	input  wire logic [1:0]  I_HTRANS,
	input  wire logic        I_HWRITE,
	input  wire logic [2:0]  I_HSIZE,
	input  wire logic [31:0] I_HWDATA,
	input  wire logic        I_HREADY,
	output logic      [31:0] O_HRDATA,
	output logic             O_HREADYOUT,
	output logic             O_HRESP,
	// Wake and line events
	input  wire logic        I_FRAME_WAKE,
	input  wire logic        I_LINE_ENERGY,
	input  wire logic        I_EEPROM_DONE,
	// Wake indication
	output logic             O_WAKE_EVENT,
	output logic             O_HOST_IRQ,
	// Clock gating and PHY power
	output logic             O_INT_CLK_EN,
	output logic             O_MAC_CLK_EN,
	output logic             O_HOST_CLK_EN,
	output logic             O_RX_PM_EN,
	output logic             O_WAKE_DET_EN,
	output logic             O_PHY_POWER,
	// Reset distribution
	output logic             O_RST_PLL,
	output logic             O_RST_HOST,
	output logic             O_RST_KEEP,
	output logic             O_RST_MII,
	output logic             O_RST_MAC,
	output logic             O_RST_PHY,
	output logic             O_EEPROM_LOAD,
	output logic             O_STRAP_LATCH
);
	// ****************************************
	// Parameter check
	// ****************************************
	if (P_RESUME_CYC == 0 || P_RESUME_CYC > pswrc_pkg::RESUME_MAX)
	begin : g_bad
		$error("pswrc_top: resume delay over 2 ms");
	end

	// ****************************************
	// Declarations
	// ****************************************
	pswrc_pkg::pswrc_state_t state;
	pswrc_pkg::pswrc_state_t next_state;
	logic        out_en, frm_en, car_en, pls_sel;
	logic        interrupt_status_register, int_en, gpd, edpd, eflag, ebusy;
	logic        energy_q, src_q;
	logic [1:0]  wst;
	logic        next_out_en, next_frm_en, next_car_en, next_pls_sel;
	logic        next_interrupt_status_register, next_int_en, next_gpd, next_edpd;
	logic        next_eflag, next_ebusy, next_energy_q, next_src_q;
	logic [1:0]  next_wst;
	logic        dp_wr, dp_rd, rd_ok;
	logic [7:0]  dp_addr;
	logic        next_dp_wr, next_dp_rd, next_rd_ok;
	logic [7:0]  next_dp_addr;
	logic [31:0] next_hrdata;
	logic        ready, sleep, acc, we, wake_wr, ext;
	logic        frame_ev, car_ev, src;
	logic        pls_busy, res_busy, res_done, phy_busy, soft_busy;
	logic        phy_start, soft_start, reload;

	// ****************************************
	// Read decode
	// ****************************************
	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		logic [31:0] d;
		d = '0;
		case (a)
			pswrc_pkg::OFS_PWR: begin
				d[pswrc_pkg::PWR_READY]   = ready;
				d[pswrc_pkg::PWR_OUT_EN]  = out_en;
				d[pswrc_pkg::PWR_FRM_EN]  = frm_en;
				d[pswrc_pkg::PWR_CAR_EN]  = car_en;
				d[pswrc_pkg::PWR_PULSE]   = pls_sel;
				d[pswrc_pkg::PWR_WST+:2]  = wst;
				d[pswrc_pkg::PWR_PHY_RST] = phy_busy;
				d[pswrc_pkg::PWR_SEL+:2]  = (state == pswrc_pkg::ST_LISTEN) ?
					pswrc_pkg::SEL_LISTEN : (state == pswrc_pkg::ST_DEEP) ?
					pswrc_pkg::SEL_DEEP : pswrc_pkg::SEL_FULL;
			end
			pswrc_pkg::OFS_INT: d[pswrc_pkg::INT_WAKE] = interrupt_status_register;
			pswrc_pkg::OFS_IEN: d[pswrc_pkg::INT_WAKE] = int_en;
			pswrc_pkg::OFS_PHY: begin
				d[pswrc_pkg::PHY_GPD]   = gpd;
				d[pswrc_pkg::PHY_EDPD]  = edpd;
				d[pswrc_pkg::PHY_ON]    = O_PHY_POWER;
				d[pswrc_pkg::PHY_EFLAG] = eflag;
			end
			pswrc_pkg::OFS_RST: begin
				d[pswrc_pkg::RST_SOFT]  = soft_busy;
				d[pswrc_pkg::RST_EBUSY] = ebusy;
			end
			default: d = '0;
		endcase
		if (!ready && a != pswrc_pkg::OFS_PWR) begin
			d = '0;
		end
		return d;
	endfunction : rd_mux

	// ****************************************
	// Decodes
	// ****************************************
	assign ext      = ~I_EXT_RESET_N;
	assign ready    = (state == pswrc_pkg::ST_FULL);
	assign sleep    = (state == pswrc_pkg::ST_LISTEN) ||
		(state == pswrc_pkg::ST_DEEP);
	assign acc      = I_HSEL & I_HTRANS[1] & I_HREADY &
		(I_HSIZE == pswrc_pkg::HSIZE_WORD);
	assign we       = dp_wr & (ready | dp_addr == pswrc_pkg::OFS_WAKE);
	assign wake_wr  = dp_wr & sleep & (dp_addr == pswrc_pkg::OFS_WAKE);
	assign frame_ev = I_FRAME_WAKE & (state == pswrc_pkg::ST_LISTEN);
	assign car_ev   = I_LINE_ENERGY & (state == pswrc_pkg::ST_DEEP);
	// Wake source, also the interrupt source
	assign src = (wst == pswrc_pkg::WST_FRAME & frm_en) |
		(wst == pswrc_pkg::WST_CARRIER & car_en);
	assign soft_start = we & (dp_addr == pswrc_pkg::OFS_RST) &
		I_HWDATA[pswrc_pkg::RST_SOFT];
	// PHY reset from control bit or powerdown release
	assign phy_start = (we & (dp_addr == pswrc_pkg::OFS_PWR) &
		I_HWDATA[pswrc_pkg::PWR_PHY_RST]) | (gpd & ~next_gpd);

	// ****************************************
	// Power, wake and status registers
	// ****************************************
	always_comb begin
		next_state    = state;
		next_out_en   = out_en;
		next_frm_en   = frm_en;
		next_car_en   = car_en;
		next_pls_sel  = pls_sel;
		next_wst      = wst;
		next_interrupt_status_register  = interrupt_status_register;
		next_int_en   = int_en;
		next_gpd      = gpd;
		next_edpd     = edpd;
		next_eflag    = eflag;
		next_ebusy    = ebusy;
		next_energy_q = I_LINE_ENERGY;
		next_src_q    = src;
		if (we && dp_addr == pswrc_pkg::OFS_PWR) begin
			next_out_en  = I_HWDATA[pswrc_pkg::PWR_OUT_EN];
			next_frm_en  = I_HWDATA[pswrc_pkg::PWR_FRM_EN];
			next_car_en  = I_HWDATA[pswrc_pkg::PWR_CAR_EN];
			next_pls_sel = I_HWDATA[pswrc_pkg::PWR_PULSE];
			next_wst     = wst & ~I_HWDATA[pswrc_pkg::PWR_WST+:2];
			if (I_HWDATA[pswrc_pkg::PWR_SEL+:2] == pswrc_pkg::SEL_LISTEN) begin
				next_state = pswrc_pkg::ST_LISTEN;
			end else if (I_HWDATA[pswrc_pkg::PWR_SEL+:2] ==
				pswrc_pkg::SEL_DEEP) begin
				next_state = pswrc_pkg::ST_DEEP;
			end
		end
		if (wake_wr) begin
			next_state = pswrc_pkg::ST_RESUME;
		end
		if (res_done) begin
			next_state = pswrc_pkg::ST_FULL;
		end
		// Detections win over a clearing write
		if (frame_ev) begin
			next_wst = pswrc_pkg::WST_FRAME;
		end
		if (car_ev) begin
			next_wst = pswrc_pkg::WST_CARRIER;
		end
		if (we && dp_addr == pswrc_pkg::OFS_INT &&
			I_HWDATA[pswrc_pkg::INT_WAKE] && !src) begin
			next_interrupt_status_register = 1'b0;
		end
		if (src) begin
			next_interrupt_status_register = 1'b1;
		end
		if (we && dp_addr == pswrc_pkg::OFS_IEN) begin
			next_int_en = I_HWDATA[pswrc_pkg::INT_WAKE];
		end
		if (we && dp_addr == pswrc_pkg::OFS_PHY) begin
			next_gpd  = I_HWDATA[pswrc_pkg::PHY_GPD];
			next_edpd = I_HWDATA[pswrc_pkg::PHY_EDPD];
			if (I_HWDATA[pswrc_pkg::PHY_EFLAG]) begin
				next_eflag = 1'b0;
			end
		end
		if (edpd && I_LINE_ENERGY && !energy_q) begin
			next_eflag = 1'b1;
		end
		if (I_EEPROM_DONE) begin
			next_ebusy = 1'b0;
		end
		if (reload) begin
			next_ebusy = 1'b1;
		end
		// Pin reset clears state, controls and flags; ebusy is left to the reload
		if (ext) begin
			next_state   = pswrc_pkg::ST_FULL;
			next_out_en  = 1'b0;
			next_frm_en  = 1'b0;
			next_car_en  = 1'b0;
			next_pls_sel = 1'b0;
			next_wst     = pswrc_pkg::WST_NONE;
			next_interrupt_status_register = 1'b0;
			next_int_en  = 1'b0;
			next_gpd     = 1'b0;
			next_edpd    = 1'b0;
			next_eflag   = 1'b0;
		end
	end

	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			state    <= pswrc_pkg::ST_FULL;
			out_en   <= 1'b0;
			frm_en   <= 1'b0;
			car_en   <= 1'b0;
			pls_sel  <= 1'b0;
			wst      <= pswrc_pkg::WST_NONE;
			interrupt_status_register  <= 1'b0;
			int_en   <= 1'b0;
			gpd      <= 1'b0;
			edpd     <= 1'b0;
			eflag    <= 1'b0;
			ebusy    <= 1'b0;
			energy_q <= 1'b0;
			src_q    <= 1'b0;
		end else begin
			state    <= next_state;
			out_en   <= next_out_en;
			frm_en   <= next_frm_en;
			car_en   <= next_car_en;
			pls_sel  <= next_pls_sel;
			wst      <= next_wst;
			interrupt_status_register  <= next_interrupt_status_register;
			int_en   <= next_int_en;
			gpd      <= next_gpd;
			edpd     <= next_edpd;
			eflag    <= next_eflag;
			ebusy    <= next_ebusy;
			energy_q <= next_energy_q;
			src_q    <= next_src_q;
		end
	end

	// ****************************************
	// Bus slave: writes zero wait, reads one wait
	// ****************************************
	always_comb begin
		next_dp_wr   = acc & I_HWRITE;
		next_dp_rd   = acc & ~I_HWRITE;
		next_dp_addr = (I_HADDR[31:8] == 24'h000000) ?
			I_HADDR[7:0] : pswrc_pkg::OFS_NONE;
		next_rd_ok   = 1'b0;
		next_hrdata  = O_HRDATA;
		if (dp_rd && !rd_ok) begin
			next_dp_wr   = 1'b0;
			next_dp_rd   = 1'b1;
			next_dp_addr = dp_addr;
			next_rd_ok   = 1'b1;
			next_hrdata  = rd_mux(dp_addr);
		end
	end

	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			dp_wr    <= 1'b0;
			dp_rd    <= 1'b0;
			rd_ok    <= 1'b0;
			dp_addr  <= 8'h00;
			O_HRDATA <= 32'h00000000;
		end else begin
			dp_wr    <= next_dp_wr;
			dp_rd    <= next_dp_rd;
			rd_ok    <= next_rd_ok;
			dp_addr  <= next_dp_addr;
			O_HRDATA <= next_hrdata;
		end
	end

	assign O_HREADYOUT = ~(dp_rd & ~rd_ok);
	assign O_HRESP     = 1'b0;

	// ****************************************
	// Timers on the always-running clock
	// ****************************************
	pswrc_timer #(.W(pswrc_pkg::TMR_W), .CNT(P_PULSE_CYC)) u_pulse (
		.i_clk(I_SYS_CLK), .i_rst(I_SYS_RST),
		.i_start(src & ~src_q), .i_stop(ext),
		.o_busy(pls_busy), .o_done());
	pswrc_timer #(.W(pswrc_pkg::TMR_W), .CNT(P_RESUME_CYC)) u_resume (
		.i_clk(I_SYS_CLK), .i_rst(I_SYS_RST),
		.i_start(wake_wr), .i_stop(ext),
		.o_busy(res_busy), .o_done(res_done));
	pswrc_timer #(.W(pswrc_pkg::TMR_W), .CNT(P_PHY_CYC)) u_phy (
		.i_clk(I_SYS_CLK), .i_rst(I_SYS_RST),
		.i_start(phy_start), .i_stop(ext),
		.o_busy(phy_busy), .o_done());
	pswrc_timer #(.W(pswrc_pkg::TMR_W), .CNT(pswrc_pkg::SOFT_RST_CYC))
	u_soft (
		.i_clk(I_SYS_CLK), .i_rst(I_SYS_RST),
		.i_start(soft_start), .i_stop(ext),
		.o_busy(soft_busy), .o_done());

	// Reset distribution
	pswrc_rst_dist u_rst (
		.i_clk(I_SYS_CLK), .i_rst(I_SYS_RST), .i_ext(ext),
		.i_soft(soft_busy), .i_phy(phy_busy),
		.o_rst_pll(O_RST_PLL), .o_rst_host(O_RST_HOST),
		.o_rst_keep(O_RST_KEEP), .o_rst_mii(O_RST_MII),
		.o_rst_mac(O_RST_MAC), .o_rst_phy(O_RST_PHY),
		.o_reload(reload), .o_strap(O_STRAP_LATCH));

	// ****************************************
	// Outputs
	// ****************************************
	// Wake pin: pulsed or static, dropped with its cause
	assign O_WAKE_EVENT  = out_en & src & (~pls_sel | pls_busy);
	assign O_HOST_IRQ    = interrupt_status_register & int_en;
	assign O_INT_CLK_EN  = (state != pswrc_pkg::ST_DEEP);
	assign O_MAC_CLK_EN  = ~sleep;
	assign O_HOST_CLK_EN = ~sleep;
	assign O_RX_PM_EN    = (state == pswrc_pkg::ST_LISTEN);
	assign O_WAKE_DET_EN = (state == pswrc_pkg::ST_LISTEN);
	// Deep sleep holds the PHY in energy-detect powerdown
	assign O_PHY_POWER   = ~gpd & ~((edpd | state == pswrc_pkg::ST_DEEP) &
		~I_LINE_ENERGY);
	assign O_EEPROM_LOAD = reload;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_SYS_RST);

	a_listen_entry: assert property (
		ready && we && dp_addr == pswrc_pkg::OFS_PWR && I_EXT_RESET_N &&
		I_HWDATA[pswrc_pkg::PWR_SEL+:2] == pswrc_pkg::SEL_LISTEN |=>
		!O_MAC_CLK_EN && !O_HOST_CLK_EN && O_INT_CLK_EN && O_RX_PM_EN &&
		!ready && state == pswrc_pkg::ST_LISTEN)
		else $error("wake-listen entry wrong");
	a_frame_wst: assert property (
		frame_ev && I_EXT_RESET_N |=> wst == pswrc_pkg::WST_FRAME)
		else $error("frame wake status not set");
	a_out_gate: assert property (
		O_WAKE_EVENT |-> out_en && src)
		else $error("wake output without cause");
	a_int_set: assert property (
		src && I_EXT_RESET_N |=> interrupt_status_register)
		else $error("wake status bit not set");
	a_wake_back: assert property (
		wake_wr && I_EXT_RESET_N |=> state == pswrc_pkg::ST_RESUME &&
		res_busy && O_MAC_CLK_EN)
		else $error("wake write ignored");
	a_deep_entry: assert property (
		ready && we && dp_addr == pswrc_pkg::OFS_PWR && I_EXT_RESET_N &&
		I_HWDATA[pswrc_pkg::PWR_SEL+:2] == pswrc_pkg::SEL_DEEP |=>
		!O_INT_CLK_EN && !O_HOST_CLK_EN && !ready)
		else $error("deep sleep entry wrong");
	a_carrier_now: assert property (
		state == pswrc_pkg::ST_DEEP && I_LINE_ENERGY && car_en &&
		I_EXT_RESET_N |=> wst == pswrc_pkg::WST_CARRIER ##1 interrupt_status_register)
		else $error("carrier not reported");
	a_static_out: assert property (
		out_en && src && !pls_sel |-> O_WAKE_EVENT)
		else $error("static wake output missing");
	a_sleep_block: assert property (
		dp_wr && !ready && dp_addr == pswrc_pkg::OFS_IEN && I_EXT_RESET_N
		|=> $stable(int_en))
		else $error("write accepted in sleep");
	a_resume_ready: assert property (
		state == pswrc_pkg::ST_RESUME |-> res_busy || res_done)
		else $error("resume without timer");
	a_phy_rst: assert property (
		phy_start && I_EXT_RESET_N |=> phy_busy ##1 O_RST_PHY)
		else $error("PHY reset not started");
	a_phy_down: assert property (
		gpd |-> !O_PHY_POWER)
		else $error("PHY powered in powerdown");
	a_irq_gate: assert property (
		O_HOST_IRQ |-> int_en && interrupt_status_register)
		else $error("interrupt without enable");

	c_listen_wake: cover property (
		state == pswrc_pkg::ST_LISTEN && frame_ev ##[1:20] wake_wr);
	c_deep_wake: cover property (
		state == pswrc_pkg::ST_DEEP ##1 car_ev ##[1:20] wake_wr);
	c_pulse_end: cover property ($fell(pls_busy) && src && pls_sel);
endmodule : pswrc_top

//--- testbench/pswrc_host.sv
`timescale 1ns/1ps
module pswrc_host (
	// Bus clock and answer
	input  wire logic        i_clk,
	input  wire logic        i_hready,
	input  wire logic [31:0] i_hrdata,
	// Request
	output logic             o_hsel,
	output logic [31:0]      o_haddr,
	output logic [1:0]       o_htrans,
	output logic             o_hwrite,
	output logic [2:0]       o_hsize,
	output logic [31:0]      o_hwdata
);
	// Idle bus from time zero
	initial begin
		o_hsel = 1'h0;
		o_haddr = 32'h0;
		o_htrans = 2'h0;
		o_hwrite = 1'h0;
		o_hsize = pswrc_pkg::HSIZE_WORD;
		o_hwdata = 32'h0;
	end
	// One word transfer; ready and read data taken at rising edges
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge i_clk);
		o_hsel <= 1'h1;
		o_htrans <= 2'h2;
		o_hwrite <= w;
		o_haddr <= {24'h0, a};
		do @(posedge i_clk); while (i_hready !== 1'h1);
		o_htrans <= 2'h0;
		o_hwdata <= d;
		do @(posedge i_clk); while (i_hready !== 1'h1);
		q = i_hrdata;
	endtask : xfer
endmodule : pswrc_host

//--- testbench/pswrc_tb_top.sv
`timescale 1ns/1ps
module pswrc_tb_top;
	logic        clk, rst, rst_n, frame, energy, edone, hsel, hwrite, rdy;
	logic        wake, irq, iclk, mclk, det, r_pll, r_keep, r_phy;
	logic        r_host, r_mii, r_mac;
	logic        hresp, hclk, rxpm, pwr, load, strap;
	int          loads, straps;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, v;
	int          failures, check_count, n;

	pswrc_top #(.P_PULSE_CYC(20), .P_RESUME_CYC(10), .P_PHY_CYC(15))
	pswrc_top_inst (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_EXT_RESET_N(rst_n),
		.I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
		.I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(rdy),
		.O_HRDATA(hrdata), .O_HREADYOUT(rdy), .O_HRESP(hresp),
		.I_FRAME_WAKE(frame), .I_LINE_ENERGY(energy), .I_EEPROM_DONE(edone),
		.O_WAKE_EVENT(wake), .O_HOST_IRQ(irq), .O_INT_CLK_EN(iclk),
		.O_MAC_CLK_EN(mclk), .O_HOST_CLK_EN(hclk), .O_RX_PM_EN(rxpm),
		.O_WAKE_DET_EN(det), .O_PHY_POWER(pwr), .O_RST_PLL(r_pll),
		.O_RST_HOST(r_host), .O_RST_KEEP(r_keep), .O_RST_MII(r_mii),
		.O_RST_MAC(r_mac), .O_RST_PHY(r_phy), .O_EEPROM_LOAD(load),
		.O_STRAP_LATCH(strap));
	pswrc_host pswrc_host_inst (.i_clk(clk), .i_hready(rdy),
		.i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans),
		.o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a);
		pswrc_host_inst.xfer(1'h0, a, 32'h0, v);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		pswrc_host_inst.xfer(1'h1, a, d, v);
	endtask : wr
	// Only reads while waking, bounded poll of ready
	task automatic wake_up();
		wr(pswrc_pkg::OFS_WAKE, 32'h0);
		rd(pswrc_pkg::OFS_PWR);
		for (int i = 0; i < 8 && v[0] !== 1'h1; i++) rd(pswrc_pkg::OFS_PWR);
		chk(v[0], 1'h1);
		chk(v[13:12], pswrc_pkg::SEL_FULL);
	endtask : wake_up
	task automatic pulse_done();
		@(posedge clk);
		edone <= 1'h1;
		@(posedge clk);
		edone <= 1'h0;
	endtask : pulse_done
	task automatic final_report();
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report

	// Count reload and strap latch pulses
	always @(posedge clk) begin
		loads  <= loads + int'(load);
		straps <= straps + int'(strap);
	end

	// Clock at 4 ns
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	// Watchdog far beyond the expected run
	initial begin
		#100us;
		failures++;
		final_report();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		{rst, rst_n, frame, energy, edone} = 5'b11010;
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		repeat (4) @(posedge clk);
		rd(pswrc_pkg::OFS_RST);
		chk(v[1], 1'h1);
		chk(loads, 1);
		chk(straps, 1);
		pulse_done();
		rd(pswrc_pkg::OFS_RST);
		chk(v[1], 1'h0);
		// Wake-listen, static output, frame wake
		wr(pswrc_pkg::OFS_PWR, 32'h1006);
		@(negedge clk);
		chk({mclk, hclk, det, rxpm, iclk, hresp}, 6'b001110);
		rd(pswrc_pkg::OFS_PWR);
		chk(v[0], 1'h0);
		rd(pswrc_pkg::OFS_PHY);
		chk(v, 32'h0);
		@(posedge clk);
		frame <= 1'h1;
		@(posedge clk);
		frame <= 1'h0;
		repeat (4) @(negedge clk);
		chk(wake, 1'h1);
		rd(pswrc_pkg::OFS_PWR);
		chk(v[6:5], pswrc_pkg::WST_FRAME);
		wake_up();
		rd(pswrc_pkg::OFS_INT);
		chk(v[0], 1'h1);
		wr(pswrc_pkg::OFS_IEN, 32'h1);
		wr(pswrc_pkg::OFS_INT, 32'h1);
		rd(pswrc_pkg::OFS_INT);
		chk({v[0], irq, wake}, 3'b111);
		wr(pswrc_pkg::OFS_PWR, 32'h0066);
		@(negedge clk);
		chk(wake, 1'h0);
		wr(pswrc_pkg::OFS_INT, 32'h1);
		@(negedge clk);
		chk(irq, 1'h0);
		$display("test wake-listen done");
		// Deep sleep, carrier already present, pulsed output
		wr(pswrc_pkg::OFS_PHY, 32'h2);
		wr(pswrc_pkg::OFS_PWR, 32'h201A);
		n = 0;
		@(negedge clk);
		chk({iclk, mclk, hclk, pwr}, 4'b0001);
		repeat (60) begin
			@(negedge clk);
			n += int'(wake);
		end
		chk(n, 20);
		rd(pswrc_pkg::OFS_PWR);
		chk(v[6:5], pswrc_pkg::WST_CARRIER);
		wake_up();
		wr(pswrc_pkg::OFS_PHY, 32'h0);
		wr(pswrc_pkg::OFS_PWR, 32'h0060);
		wr(pswrc_pkg::OFS_INT, 32'h1);
		$display("test deep sleep done");
		// PHY reset bit and reset distribution
		wr(pswrc_pkg::OFS_PWR, 32'h400);
		rd(pswrc_pkg::OFS_PWR);
		chk({v[10], r_phy, r_mac}, 3'b110);
		repeat (30) @(negedge clk);
		rd(pswrc_pkg::OFS_PWR);
		chk(v[10], 1'h0);
		// General powerdown, then release restarts the PHY
		wr(pswrc_pkg::OFS_PHY, 32'h1);
		@(negedge clk);
		chk(pwr, 1'h0);
		wr(pswrc_pkg::OFS_PHY, 32'h0);
		rd(pswrc_pkg::OFS_PWR);
		chk({v[10], pwr}, 2'b11);
		repeat (30) @(negedge clk);
		wr(pswrc_pkg::OFS_RST, 32'h1);
		repeat (5) @(negedge clk);
		chk({r_pll, r_keep, r_phy, r_host, r_mii, r_mac}, 6'h07);
		repeat (520) @(negedge clk);
		rd(pswrc_pkg::OFS_RST);
		chk(v[1:0], 2'b10);
		pulse_done();
		rd(pswrc_pkg::OFS_RST);
		chk(v[1], 1'h0);
		chk(loads, 2);
		chk(straps, 1);
		// Pin reset holds every domain, then reloads and latches
		@(posedge clk);
		rst_n <= 1'h0;
		repeat (3) @(negedge clk);
		chk({r_pll, r_keep, r_phy, r_host, r_mii, r_mac}, 6'h3F);
		@(posedge clk);
		rst_n <= 1'h1;
		repeat (4) @(negedge clk);
		chk({r_pll, r_keep, r_phy, r_host, r_mii, r_mac}, 6'h00);
		chk(straps, 2);
		chk(loads, 3);
		$display("test resets done");
		final_report();
	end
endmodule : pswrc_tb_top
